/* File: rtl/sub_node_slot_receive_masks.sv */
// slot receive masks, channel skip and structure commit of a subordinate node
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] upstream slot 16+n is received only when mask bit n is set
// [R2] upstream slot 24+n is received only when mask bit n is set
// [R3] mask bits 3..0 enable upstream slots 11..8
// [R4] downstream mask bit n enables reception of downstream slot n
// [R5] received upstream slots follow received downstream slots on the serial port
// [R6] mask and skip writes act only after a new-structure commit
// [R7] 5-bit skip count of local input channels before upstream placement
// [R8] with no downstream mask bit set, take the local downstream slot count
// [R9] mask bits 7..4 enable upstream slots 15..12
// [R10] active copies load together at commit, never mixed within a superframe
module sub_node_slot_receive_masks
   import slot_mask_pkg::*;
(
   // clock and synchronous reset
   input  wire logic              aclk,
   input  wire logic              aresetn,

   // axi4-lite register port
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,

   // bus slot offers, same clock as the register port
   input  wire logic              superframe_start,
   input  wire logic              bus_slot_valid,
   input  wire logic              bus_slot_upstream,
   input  wire logic [SLOT_W-1:0] bus_slot_index,
   input  wire logic [CHAN_W-1:0] local_downstream_slot_count,

   // local serial or pulse-density input channels
   input  wire logic              local_ch_valid,
   input  wire logic [SKIP_W-1:0] local_ch_index,

   // decisions, all registered
   output logic                   slot_rx_take,
   output logic [CHAN_W-1:0]      slot_rx_channel,
   output logic                   local_ch_to_bus,
   output logic [SKIP_W-1:0]      local_ch_bus_position,
   output logic                   structure_applied
);

   typedef struct packed
   {
      // register port handshake
      bus_state_t             st;
      logic                   aw_held;
      logic [IDX_W-1:0]       aw_idx;
      logic                   w_held;
      logic [MASK_W-1:0]      w_data;
      logic                   w_lane0;
      logic                   aw_ready;
      logic                   w_ready;
      logic                   ar_ready;
      logic                   b_valid;
      logic [1:0]             b_resp;
      logic                   r_valid;
      logic [DATA_W-1:0]      r_data;
      logic [1:0]             r_resp;

      // software-visible pending copies
      logic [UP_MASK_W-1:0]   pend_up;
      logic [MASK_W-1:0]      pend_dn;
      logic [SKIP_W-1:0]      pend_skip;

      // copies the slot logic runs on
      logic [UP_MASK_W-1:0]   act_up;
      logic [MASK_W-1:0]      act_dn;
      logic [SKIP_W-1:0]      act_skip;

      // commit bookkeeping
      logic                   armed;
      logic                   ever_applied;

      // per-superframe counting and decisions
      logic [CHAN_W-1:0]      dn_taken;
      logic [CHAN_W-1:0]      up_taken;
      logic                   take;
      logic [CHAN_W-1:0]      channel;
      logic                   to_bus;
      logic [SKIP_W-1:0]      bus_pos;
      logic                   applied;
   } state_t;

   // one state value and its next copy; bus slave and slot logic share it
   state_t r;
   state_t next_r;
   logic   slot_take;

   // decode shared by the write and read paths
   // the control index is our own; it carries commit and status
   function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
      case (idx)
         IDX_UP_MASK_8_15,
         IDX_UP_MASK_16_23,
         IDX_UP_MASK_24_31,
         IDX_UP_SKIP,
         IDX_DN_MASK_0_7,
         IDX_STRUCT_CTRL: is_mapped = 1'b1;
         default:         is_mapped = 1'b0;
      endcase
   endfunction : is_mapped

   // software reads the pending copies, not the active ones
   // unused bits read as zero, so a read value may be written back
   function automatic logic [DATA_W-1:0] read_word(input state_t s,
                                                   input logic [IDX_W-1:0] idx);
      read_word = '0;
      case (idx)
         IDX_UP_MASK_8_15:  read_word[MASK_W-1:0] = s.pend_up[7:0];
         IDX_UP_MASK_16_23: read_word[MASK_W-1:0] = s.pend_up[15:8];
         IDX_UP_MASK_24_31: read_word[MASK_W-1:0] = s.pend_up[23:16];
         IDX_UP_SKIP:       read_word[SKIP_W-1:0] = s.pend_skip;
         IDX_DN_MASK_0_7:   read_word[MASK_W-1:0] = s.pend_dn;
         // status: commit pending, and settings applied at least once
         IDX_STRUCT_CTRL:
         begin
            read_word[PENDING_BIT] = s.armed;
            read_word[ACTIVE_BIT]  = s.ever_applied;
         end
         default:           read_word = '0;
      endcase
   endfunction : read_word

   // the slot decision sees only the active copies
   slot_select u_slot_select // R1 R2 R3 R4 R8 R9
   (
      .up_mask    (r.act_up),
      .dn_mask    (r.act_dn),
      .ldn_count  (local_downstream_slot_count),
      .dn_taken   (r.dn_taken),
      .upstream   (bus_slot_upstream),
      .slot_index (bus_slot_index),
      .take       (slot_take)
   );

   // whole next state; bus slave, pending/active copies, slot counting
   // every field starts from its old value, so a silent path holds it
   always_comb
   begin
      logic aw_fire;
      logic w_fire;
      logic ar_fire;
      logic do_write;
      logic commit_wr;
      logic load;

      next_r    = r;
      aw_fire   = s_axi_awvalid & r.aw_ready;
      w_fire    = s_axi_wvalid & r.w_ready;
      ar_fire   = s_axi_arvalid & r.ar_ready;
      do_write  = 1'b0;
      commit_wr = 1'b0;
      load      = superframe_start & r.armed;

      // address and data may arrive in either order
      // each half is held until the other one arrives
      if (aw_fire)
      begin
         next_r.aw_held = 1'b1;
         next_r.aw_idx  = s_axi_awaddr[IDX_LSB +: IDX_W];
      end
      if (w_fire)
      begin
         next_r.w_held  = 1'b1;
         next_r.w_data  = s_axi_wdata[MASK_W-1:0];
         next_r.w_lane0 = s_axi_wstrb[0];
      end

      // one transfer at a time; a held write goes first
      case (r.st)
         BUS_IDLE:
         begin
            if (r.aw_held & r.w_held)
            begin
               do_write       = r.w_lane0 & is_mapped(r.aw_idx);
               next_r.aw_held = 1'b0;
               next_r.w_held  = 1'b0;
               next_r.b_valid = 1'b1;
               next_r.b_resp  = is_mapped(r.aw_idx) ? RESP_OKAY : RESP_SLVERR;
               next_r.st      = BUS_WRITE_RESP;
            end
            // a read starts only from idle, never beside a write
            else if (ar_fire)
            begin
               next_r.r_valid = 1'b1;
               next_r.r_data  = read_word(r, s_axi_araddr[IDX_LSB +: IDX_W]);
               next_r.r_resp  = is_mapped(s_axi_araddr[IDX_LSB +: IDX_W]) ?
                                RESP_OKAY : RESP_SLVERR;
               next_r.st      = BUS_READ_DATA;
            end
         end
         // the response stands until the master takes it
         BUS_WRITE_RESP:
         begin
            if (s_axi_bready)
            begin
               next_r.b_valid = 1'b0;
               next_r.st      = BUS_IDLE;
            end
         end
         // read data stay registered while rvalid stands
         BUS_READ_DATA:
         begin
            if (s_axi_rready)
            begin
               next_r.r_valid = 1'b0;
               next_r.st      = BUS_IDLE;
            end
         end
         // an unused state code returns to idle, no answer pending
         default:
         begin
            next_r.st      = BUS_IDLE;
            next_r.b_valid = 1'b0;
            next_r.r_valid = 1'b0;
         end
      endcase

      // readies are registered; a read waits while half a write is held
      // arready drops at the edge that takes an address, never counts twice
      next_r.aw_ready = (next_r.st == BUS_IDLE) & ~next_r.aw_held;
      next_r.w_ready  = (next_r.st == BUS_IDLE) & ~next_r.w_held;
      next_r.ar_ready = (next_r.st == BUS_IDLE) & ~next_r.aw_held
                        & ~next_r.w_held & ~ar_fire;

      // writes land in the pending copies only
      // with byte lane zero off a write is answered but changes nothing
      if (do_write)
      begin
         case (r.aw_idx)
            IDX_UP_MASK_8_15:  next_r.pend_up[7:0]   = r.w_data; // R6
            IDX_UP_MASK_16_23: next_r.pend_up[15:8]  = r.w_data; // R6
            IDX_UP_MASK_24_31: next_r.pend_up[23:16] = r.w_data; // R6
            IDX_UP_SKIP:       next_r.pend_skip      = r.w_data[SKIP_W-1:0]; // R6
            IDX_DN_MASK_0_7:   next_r.pend_dn        = r.w_data; // R6
            IDX_STRUCT_CTRL:   commit_wr             = r.w_data[COMMIT_BIT];
            default:           commit_wr             = 1'b0;
         endcase
      end

      // commit arms; the swap waits for a superframe boundary so that
      // a running superframe never sees a mix of old and new settings
      next_r.applied = load;
      if (load)
      begin
         next_r.act_up       = r.pend_up; // R10
         next_r.act_dn       = r.pend_dn; // R10
         next_r.act_skip     = r.pend_skip; // R10
         next_r.ever_applied = 1'b1;
      end
      // set wins, so a commit written at a boundary waits for the next one
      next_r.armed = (r.armed & ~load) | commit_wr; // R6

      // per-superframe slot counting; upstream channels follow downstream
      // six-bit counters: at most 32 slots each way, so no channel wraps
      next_r.take = 1'b0;
      if (superframe_start)
      begin
         next_r.dn_taken = '0;
         next_r.up_taken = '0;
      end
      else if (bus_slot_valid & slot_take)
      begin
         next_r.take = 1'b1;
         // upstream numbers start after every downstream slot taken so far
         if (bus_slot_upstream)
         begin
            next_r.channel  = r.dn_taken + r.up_taken; // R5
            next_r.up_taken = r.up_taken + CHAN_W'(1);
         end
         else
         begin
            next_r.channel  = r.dn_taken;
            next_r.dn_taken = r.dn_taken + CHAN_W'(1);
         end
      end

      // local input channels below the skip count never reach the bus
      // the active skip is used, so a pending change cannot split a frame
      next_r.to_bus = 1'b0;
      if (local_ch_valid & (local_ch_index >= r.act_skip))
      begin
         next_r.to_bus  = 1'b1; // R7
         next_r.bus_pos = local_ch_index - r.act_skip; // R7
      end
   end

   // single state register, synchronous reset
   // copies are reset by package name so a new reset value reaches them
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r          <= '0;
         r.st       <= BUS_IDLE;
         r.pend_up  <= UP_MASK_RST;
         r.pend_dn  <= DN_MASK_RST;
         r.pend_skip<= SKIP_RST;
         r.act_up   <= UP_MASK_RST;
         r.act_dn   <= DN_MASK_RST;
         r.act_skip <= SKIP_RST;
      end
      else
         r <= next_r;
   end

   // all outputs come straight from the state register
   // register port first
   assign s_axi_awready         = r.aw_ready;
   assign s_axi_wready          = r.w_ready;
   assign s_axi_bvalid          = r.b_valid;
   assign s_axi_bresp           = r.b_resp;
   assign s_axi_arready         = r.ar_ready;
   assign s_axi_rvalid          = r.r_valid;
   assign s_axi_rdata           = r.r_data;
   assign s_axi_rresp           = r.r_resp;

   // decisions, each one cycle behind the slot offer, local channel or superframe boundary that caused it
   assign slot_rx_take          = r.take;
   assign slot_rx_channel       = r.channel;
   assign local_ch_to_bus       = r.to_bus;
   assign local_ch_bus_position = r.bus_pos;
   assign structure_applied     = r.applied;

endmodule : sub_node_slot_receive_masks
`default_nettype wire

/* File: pkg/slot_mask_pkg.sv */
// shared constants for the subordinate node slot receive mask block
package slot_mask_pkg;

   // axi4-lite geometry
   localparam int unsigned ADDR_W      = 9;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned IDX_LSB     = 2;
   localparam int unsigned IDX_W       = 7;

   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_UP_MASK_8_15  = 7'h61;
   localparam logic [IDX_W-1:0] IDX_UP_MASK_16_23 = 7'h62;
   localparam logic [IDX_W-1:0] IDX_UP_MASK_24_31 = 7'h63;
   localparam logic [IDX_W-1:0] IDX_UP_SKIP       = 7'h64;
   localparam logic [IDX_W-1:0] IDX_DN_MASK_0_7   = 7'h65;
   localparam logic [IDX_W-1:0] IDX_STRUCT_CTRL   = 7'h6E;

   // field layout
   localparam int unsigned MASK_W      = 8;
   localparam int unsigned UP_MASK_W   = 24;
   localparam int unsigned SKIP_W      = 5;
   localparam int unsigned SLOT_W      = 5;
   localparam int unsigned CHAN_W      = 6;
   localparam int unsigned UP_BASE     = 8;
   localparam int unsigned COMMIT_BIT  = 0;
   localparam int unsigned PENDING_BIT = 0;
   localparam int unsigned ACTIVE_BIT  = 1;

   // reset values
   localparam logic [UP_MASK_W-1:0] UP_MASK_RST = 24'h000000;
   localparam logic [MASK_W-1:0]    DN_MASK_RST = 8'h00;
   localparam logic [SKIP_W-1:0]    SKIP_RST    = 5'h00;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // bus slave states, gray coded: idle to either response is one bit
   typedef enum logic [1:0]
   {
      BUS_IDLE       = 2'b00,
      BUS_WRITE_RESP = 2'b01,
      BUS_READ_DATA  = 2'b10
   } bus_state_t;

endpackage : slot_mask_pkg

/* File: rtl/slot_select.sv */
// per-slot receive decision from the active masks
`timescale 1ns/1ps
`default_nettype none
module slot_select
   import slot_mask_pkg::*;
(
   input  wire logic [UP_MASK_W-1:0] up_mask,
   input  wire logic [MASK_W-1:0]    dn_mask,
   input  wire logic [CHAN_W-1:0]    ldn_count,
   input  wire logic [CHAN_W-1:0]    dn_taken,
   input  wire logic                 upstream,
   input  wire logic [SLOT_W-1:0]    slot_index,
   output logic                      take
);

   logic [SLOT_W-1:0] up_bit;

   // upstream slots below the base belong to the mask kept outside
   always_comb
   begin
      up_bit = slot_index - SLOT_W'(UP_BASE);
      take   = 1'b0;
      if (upstream)
      begin
         if (slot_index >= SLOT_W'(UP_BASE))
            take = up_mask[up_bit]; // R1 R2 R3 R9
      end
      else if (dn_mask == DN_MASK_RST)
         take = (dn_taken < ldn_count); // R8
      else if (slot_index < SLOT_W'(MASK_W))
         take = dn_mask[slot_index[2:0]]; // R4
   end

endmodule : slot_select
`default_nettype wire

/* File: bench/slot_mask_chk.sv */
// port-level checks for the slot receive mask block
`timescale 1ns/1ps
`default_nettype none
module slot_mask_chk
   import slot_mask_pkg::*;
(
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic              superframe_start,
   input wire logic              bus_slot_valid,
   input wire logic              bus_slot_upstream,
   input wire logic [SLOT_W-1:0] bus_slot_index,
   input wire logic              local_ch_valid,
   input wire logic [SKIP_W-1:0] local_ch_index,
   input wire logic              slot_rx_take,
   input wire logic [CHAN_W-1:0] slot_rx_channel,
   input wire logic              local_ch_to_bus,
   input wire logic [SKIP_W-1:0] local_ch_bus_position,
   input wire logic              structure_applied
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // slot acceptance is tied to an offer one cycle earlier
   property p_take_cause; slot_rx_take |-> $past(bus_slot_valid); endproperty
   a_take_cause: assert property (p_take_cause) else $error("take without offer");
   property p_up_low;
      bus_slot_valid && bus_slot_upstream && bus_slot_index < 5'h08 |=> !slot_rx_take;
   endproperty
   a_up_low: assert property (p_up_low) else $error("low upstream slot taken");
   // counters restart at a superframe, so the first slot taken lands on channel 0
   property p_first_chan;
      superframe_start ##1 !bus_slot_valid ##1 !bus_slot_valid ##1 bus_slot_valid
         ##1 slot_rx_take |-> slot_rx_channel == 6'h00;
   endproperty
   a_first_chan: assert property (p_first_chan) else $error("first channel not 0");
   property p_chan_hold; !slot_rx_take |-> $stable(slot_rx_channel); endproperty
   a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
   // a forwarded channel never sits above its own input number
   property p_skip_pos;
      local_ch_to_bus |-> $past(local_ch_valid) && local_ch_bus_position <= $past(local_ch_index);
   endproperty
   a_skip_pos: assert property (p_skip_pos) else $error("bad bus position");
   property p_pos_hold; !local_ch_to_bus |-> $stable(local_ch_bus_position); endproperty
   a_pos_hold: assert property (p_pos_hold) else $error("position moved");
   // settings only switch on a superframe boundary
   property p_applied_cause; structure_applied |-> $past(superframe_start); endproperty
   a_applied_cause: assert property (p_applied_cause) else $error("applied off boundary");
   property p_applied_pulse; structure_applied |=> !structure_applied; endproperty
   a_applied_pulse: assert property (p_applied_pulse) else $error("applied too long");
endmodule : slot_mask_chk

bind sub_node_slot_receive_masks slot_mask_chk u_chk
(
   .aclk(aclk), .aresetn(aresetn), .superframe_start(superframe_start),
   .bus_slot_valid(bus_slot_valid), .bus_slot_upstream(bus_slot_upstream),
   .bus_slot_index(bus_slot_index), .local_ch_valid(local_ch_valid),
   .local_ch_index(local_ch_index), .slot_rx_take(slot_rx_take),
   .slot_rx_channel(slot_rx_channel), .local_ch_to_bus(local_ch_to_bus),
   .local_ch_bus_position(local_ch_bus_position), .structure_applied(structure_applied)
);
`default_nettype wire

/* File: bench/slot_bus_model.sv */
// bus-side partner: superframe boundaries and slot offers
`timescale 1ns/1ps
`default_nettype none
module slot_bus_model
   import slot_mask_pkg::*;
(
   input  wire logic              aclk,
   output logic                   superframe_start,
   output logic                   bus_slot_valid,
   output logic                   bus_slot_upstream,
   output logic [SLOT_W-1:0]      bus_slot_index
);
   // idle bus at time zero
   initial
   begin
      superframe_start  = 1'h0;
      bus_slot_valid    = 1'h0;
      bus_slot_upstream = 1'h0;
      bus_slot_index    = 5'h00;
   end

   // released lines flip so a stale slot number is never mistaken for a fresh one
   task automatic offer(input logic up, input logic [SLOT_W-1:0] idx);
      @(posedge aclk);
      bus_slot_valid    <= 1'h1;
      bus_slot_upstream <= up;
      bus_slot_index    <= idx;
      @(posedge aclk);
      bus_slot_valid    <= 1'h0;
      bus_slot_upstream <= ~up;
      bus_slot_index    <= ~idx;
   endtask : offer

   // one-cycle boundary mark, never together with a slot offer
   task automatic frame();
      @(posedge aclk);
      superframe_start <= 1'h1;
      @(posedge aclk);
      superframe_start <= 1'h0;
   endtask : frame
endmodule : slot_bus_model
`default_nettype wire

/* File: bench/sub_node_slot_receive_masks_test.sv */
// self-checking bench for the slot receive mask block
`timescale 1ns/1ps
`default_nettype none
module sub_node_slot_receive_masks_test;
   import slot_mask_pkg::*;
   logic              aclk = 1'h0, aresetn = 1'h0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
   logic              rready = 1'h0, lv = 1'h0;
   logic [SKIP_W-1:0] li = '0;
   logic [CHAN_W-1:0] ldn = '0;
   logic [3:0]        wstrb = 4'hF;
   wire               awready, wready, bvalid, arready, rvalid, take, to_bus, applied;
   wire               sf, sv, sup;
   wire  [1:0]        bresp, rresp;
   wire  [DATA_W-1:0] rdata;
   wire  [SLOT_W-1:0] sidx;
   wire  [CHAN_W-1:0] chan;
   wire  [SKIP_W-1:0] pos;
   int                mismatches = 0, n_checks = 0, cyc = 0;

   sub_node_slot_receive_masks dut
   (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .superframe_start(sf),
      .bus_slot_valid(sv), .bus_slot_upstream(sup), .bus_slot_index(sidx),
      .local_downstream_slot_count(ldn), .local_ch_valid(lv), .local_ch_index(li),
      .slot_rx_take(take), .slot_rx_channel(chan), .local_ch_to_bus(to_bus),
      .local_ch_bus_position(pos), .structure_applied(applied)
   );
   slot_bus_model bus
   (
      .aclk(aclk), .superframe_start(sf), .bus_slot_valid(sv),
      .bus_slot_upstream(sup), .bus_slot_index(sidx)
   );

   // clock and hang guard; the run needs well under a thousand cycles
   always #12.5 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         mismatches++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [6:0] i, input logic [31:0] d, input logic [1:0] er);
      logic done;
      done = 1'h0;
      @(posedge aclk);
      awaddr  <= {i, 2'h0};
      wdata   <= d;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      while (!done)
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
         if (bvalid)
         begin
            bready <= 1'h0;
            done = 1'h1;
            chk("bresp", 32'(bresp), 32'(er));
         end
      end
   endtask : wr

   task automatic rd(input logic [6:0] i, input logic [31:0] ed, input logic [1:0] er);
      logic done;
      done = 1'h0;
      @(posedge aclk);
      araddr  <= {i, 2'h0};
      arvalid <= 1'h1;
      rready  <= 1'h1;
      while (!done)
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'h0;
         if (rvalid)
         begin
            rready <= 1'h0;
            done = 1'h1;
            chk("rdata", rdata, ed);
            chk("rresp", 32'(rresp), 32'(er));
         end
      end
   endtask : rd

   // one bus slot, then the registered decision a cycle later
   task automatic slot(input logic up, input logic [4:0] i, input logic et, input logic [5:0] ec);
      bus.offer(up, i);
      @(posedge aclk);
      chk("take", 32'(take), 32'(et));
      if (et)
         chk("channel", 32'(chan), 32'(ec));
   endtask : slot

   // one local input channel; index lines flip once released
   task automatic lch(input logic [4:0] i, input logic eo, input logic [4:0] ep);
      @(posedge aclk);
      lv <= 1'h1;
      li <= i;
      @(posedge aclk);
      lv <= 1'h0;
      li <= ~i;
      @(posedge aclk);
      chk("to_bus", 32'(to_bus), 32'(eo));
      if (eo)
         chk("position", 32'(pos), 32'(ep));
   endtask : lch

   task automatic frm(input logic ea);
      bus.frame();
      @(posedge aclk);
      chk("applied", 32'(applied), 32'(ea));
   endtask : frm

   // main sequence
   initial
   begin
      logic [6:0]  ix [5];
      logic [7:0]  mv [5];
      logic [23:0] um;
      int          dn, up;
      ix = '{IDX_UP_MASK_8_15, IDX_UP_MASK_16_23, IDX_UP_MASK_24_31, IDX_UP_SKIP, IDX_DN_MASK_0_7};
      mv = '{8'h5A, 8'h81, 8'h3C, 8'h03, 8'h05};
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      foreach (ix[k])
         rd(ix[k], '0, RESP_OKAY);
      rd(7'h10, '0, RESP_SLVERR);
      wr(7'h10, 32'hFF, RESP_SLVERR);
      foreach (ix[k])
      begin
         wr(ix[k], {24'hFFFFFF, mv[k]}, RESP_OKAY);
         rd(ix[k], 32'(mv[k]), RESP_OKAY);
      end
      // lane zero off: answered, nothing stored
      wstrb <= 4'h0;
      wr(IDX_UP_SKIP, 32'h1F, RESP_OKAY);
      wstrb <= 4'hF;
      rd(IDX_UP_SKIP, 32'h03, RESP_OKAY);
      slot(1'h1, 5'h10, 1'h0, '0);
      slot(1'h0, 5'h00, 1'h0, '0);
      lch(5'h00, 1'h1, 5'h00);
      wr(IDX_STRUCT_CTRL, 32'h1, RESP_OKAY);
      rd(IDX_STRUCT_CTRL, 32'h1, RESP_OKAY);
      slot(1'h1, 5'h10, 1'h0, '0);
      frm(1'h1);
      rd(IDX_STRUCT_CTRL, 32'h2, RESP_OKAY);
      dn = 0;
      for (int s = 0; s < 8; s++)
      begin
         slot(1'h0, 5'(s), mv[4][s], 6'(dn));
         dn += int'(mv[4][s]);
      end
      um = {mv[2], mv[1], mv[0]};
      up = 0;
      for (int s = 0; s < 32; s++)
      begin
         slot(1'h1, 5'(s), (s >= 8) ? um[s-8] : 1'h0, 6'(dn + up));
         up += (s >= 8) ? int'(um[s-8]) : 0;
      end
      for (int c = 0; c < 6; c++)
         lch(5'(c), c >= 3, 5'(c - 3));
      wr(IDX_DN_MASK_0_7, '0, RESP_OKAY);
      ldn <= 6'h03;
      wr(IDX_STRUCT_CTRL, 32'h1, RESP_OKAY);
      frm(1'h1);
      for (int s = 0; s < 4; s++)
         slot(1'h0, 5'(s + 5), s < 3, 6'(s));
      frm(1'h0);
      slot(1'h0, 5'h1F, 1'h1, 6'h00);
      // reset in mid-run clears status and the active copies
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rd(IDX_STRUCT_CTRL, '0, RESP_OKAY);
      slot(1'h1, 5'h10, 1'h0, '0);
      give_verdict();
   end
endmodule : sub_node_slot_receive_masks_test
`default_nettype wire
